// *** rka_access_ctrl.sv ***
// Role, key custody and power-up self test controller.
// Assumes an external AES core and a byte-wide firmware ROM that
// answers one cycle after the address; commands arrive pre-framed.
`timescale 1ns/1ps
module rka_access_ctrl #(
    parameter int unsigned FW_BYTES = 32768,
    parameter logic [15:0] FW_CRC   = 16'h1d0f
) (
    // Clock and power-on reset
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    input  wire logic                    host_replug,
    // Command link from the reader
    input  wire logic                    cmd_valid,
    input  wire logic                    cmd_paired,
    input  wire logic [3:0]              cmd_code,
    input  wire logic [rka_pkg::BLK_W-1:0] cmd_data,
    output logic                         cmd_ready,
    output logic                         rsp_valid,
    output logic [1:0]                   rsp_code,
    output rka_pkg::rka_role_t           role_out,
    output logic                         init_out,
    // External AES core
    output logic                         aes_start,
    output logic                         aes_decrypt,
    output logic [rka_pkg::KEY_W-1:0]    aes_key,
    output logic [rka_pkg::BLK_W-1:0]    aes_din,
    input  wire logic                    aes_done,
    input  wire logic [rka_pkg::BLK_W-1:0] aes_dout,
    // Firmware image ROM
    output logic [15:0]                  fw_rd_addr,
    input  wire logic [7:0]              fw_rd_data,
    // Counter-mode data path and host side
    output logic [rka_pkg::KEY_W-1:0]    ctr_key,
    output logic                         ctr_key_valid,
    output logic                         host_out_en,
    output logic                         test_busy,
    output logic                         error_out
);
    import rka_pkg::*;

    typedef enum logic [2:0] {ST_CRC, ST_CRC_CHK, ST_KAT_ENC, ST_KAT_DEC,
        ST_IDLE, ST_UNWRAP, ST_ZERO, ST_ERROR} rka_state_t;

    // ==========================================================
    // Helpers
    function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                               input logic [7:0]  d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc16_byte

    function automatic logic pw_legal(input logic [PW_W-1:0] p);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < PW_CHARS; i++) begin
            if (p[i*CHAR_W +: CHAR_W] < PW_MIN_CHAR) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : pw_legal

    // ==========================================================
    // State
    rka_state_t          state_reg, state_next;
    rka_role_t           role_reg;
    logic                rst_all;
    logic                init_reg;
    logic [PW_W-1:0]     off_pw_reg, rdr_pw_reg, stg_off_reg, stg_rdr_reg;
    logic [KEY_W-1:0]    kwk_reg, stg_kwk_reg, traffic_key_reg;
    logic [2:0]          init_seen_reg;
    logic [1:0]          tk_seen_reg;
    logic [15:0]         crc_reg;
    logic [16:0]         fw_cnt_reg;
    logic [3:0]          pend_cmd_reg;
    logic                take, permit, needs_unwrap, tk_valid;

    assign rst_all  = sys_rst | host_replug;
    assign take     = cmd_valid & cmd_ready & cmd_paired;
    assign tk_valid = (tk_seen_reg == TK_ALL);
    assign needs_unwrap = (cmd_code <= CMD_TKEY_HI);

    // Permission per role and initialization
    always_comb begin
        case (cmd_code)
            CMD_AUTH_OFF: permit = 1'b1;
            CMD_AUTH_RDR: permit = init_reg;
            CMD_INIT_PW, CMD_INIT_KLO, CMD_INIT_KHI:
                permit = (role_reg == ROLE_OFFICER);
            CMD_TKEY_LO, CMD_TKEY_HI:
                permit = init_reg && (role_reg == ROLE_READER);
            CMD_DATA:
                permit = init_reg && (role_reg == ROLE_READER) && tk_valid;
            CMD_ZEROIZE, CMD_SELFTEST: permit = 1'b1;
            CMD_STATUS: permit = init_reg && (role_reg != ROLE_NONE);
            default: permit = 1'b0;
        endcase
    end

    // ==========================================================
    // Control sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_CRC:
                if (fw_cnt_reg == 17'(FW_BYTES)) state_next = ST_CRC_CHK;
            ST_CRC_CHK:
                state_next = (crc_reg == FW_CRC) ? ST_KAT_ENC : ST_ERROR;
            ST_KAT_ENC:
                if (aes_done) begin
                    state_next = (aes_dout == KAT_CT) ? ST_KAT_DEC : ST_ERROR;
                end
            ST_KAT_DEC:
                if (aes_done) begin
                    state_next = (aes_dout == KAT_PT) ? ST_IDLE : ST_ERROR;
                end
            ST_IDLE:
                if (take && permit) begin
                    if (cmd_code == CMD_ZEROIZE) state_next = ST_ZERO;
                    else if (cmd_code == CMD_SELFTEST) state_next = ST_CRC;
                    else if (needs_unwrap) state_next = ST_UNWRAP;
                end
            ST_UNWRAP:
                if (aes_done) state_next = ST_IDLE;
            ST_ZERO:
                state_next = ST_IDLE;
            ST_ERROR:
                state_next = ST_ERROR;
            default:
                state_next = ST_ERROR;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst_all) state_reg <= ST_CRC;
        else state_reg <= state_next;
    end

    // ==========================================================
    // Firmware CRC walk
    always_ff @(posedge clk_sys) begin
        if (rst_all || state_next == ST_CRC && state_reg != ST_CRC) begin
            fw_cnt_reg <= '0;
            fw_rd_addr <= '0;
            crc_reg    <= CRC_INIT;
        end else if (state_reg == ST_CRC) begin
            if (fw_cnt_reg != '0) crc_reg <= crc16_byte(crc_reg, fw_rd_data);
            fw_cnt_reg <= fw_cnt_reg + 17'h1;
            fw_rd_addr <= 16'(fw_cnt_reg + 17'h1);
        end
    end

    // ==========================================================
    // AES requests: known answers, then ECB unwrap by wrap key
    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            aes_start    <= 1'b0;
            aes_decrypt  <= 1'b0;
            aes_key      <= '0;
            aes_din      <= '0;
            pend_cmd_reg <= '0;
        end else begin
            aes_start <= 1'b0;
            if (state_reg == ST_CRC_CHK && state_next == ST_KAT_ENC) begin
                aes_start   <= 1'b1;
                aes_decrypt <= 1'b0;
                aes_key     <= KAT_KEY;
                aes_din     <= KAT_PT;
            end else if (state_reg == ST_KAT_ENC && state_next == ST_KAT_DEC)
            begin
                aes_start   <= 1'b1;
                aes_decrypt <= 1'b1;
                aes_din     <= KAT_CT;
            end else if (state_next == ST_UNWRAP && state_reg == ST_IDLE)
            begin
                aes_start    <= 1'b1;
                aes_decrypt  <= 1'b1;
                aes_key      <= kwk_reg;
                aes_din      <= cmd_data;
                pend_cmd_reg <= cmd_code;
            end else if (state_next == ST_IDLE) begin
                aes_key <= '0;
            end
        end
    end

    // ==========================================================
    // Role, secrets and initialization
    always_ff @(posedge clk_sys) begin
        if (rst_all || state_next == ST_ZERO) begin
            role_reg        <= ROLE_NONE;
            init_reg        <= 1'b0;
            off_pw_reg      <= DEF_OFF_PW;
            rdr_pw_reg      <= DEF_RDR_PW;
            kwk_reg         <= DEF_KWK;
            stg_off_reg     <= '0;
            stg_rdr_reg     <= '0;
            stg_kwk_reg     <= '0;
            init_seen_reg   <= '0;
            traffic_key_reg <= '0;
            tk_seen_reg     <= '0;
        end else if (state_reg == ST_UNWRAP && aes_done) begin
            case (pend_cmd_reg)
                CMD_AUTH_OFF, CMD_AUTH_RDR: begin
                    role_reg <= ROLE_NONE;
                    if (pw_legal(aes_dout[PW_W-1:0])) begin
                        if (pend_cmd_reg == CMD_AUTH_OFF &&
                            aes_dout[PW_W-1:0] == off_pw_reg)
                            role_reg <= ROLE_OFFICER;
                        else if (pend_cmd_reg == CMD_AUTH_RDR &&
                                 aes_dout[PW_W-1:0] == rdr_pw_reg)
                            role_reg <= ROLE_READER;
                    end
                end
                CMD_INIT_PW: begin
                    stg_off_reg   <= aes_dout[BLK_W-1:PW_W];
                    stg_rdr_reg   <= aes_dout[PW_W-1:0];
                    init_seen_reg <= init_seen_reg | 3'h1;
                end
                CMD_INIT_KLO: begin
                    stg_kwk_reg[HALF_W-1:0] <= aes_dout;
                    init_seen_reg <= init_seen_reg | 3'h2;
                end
                CMD_INIT_KHI: begin
                    stg_kwk_reg[KEY_W-1:HALF_W] <= aes_dout;
                    init_seen_reg <= init_seen_reg | 3'h4;
                end
                CMD_TKEY_LO: begin
                    traffic_key_reg[HALF_W-1:0] <= aes_dout;
                    tk_seen_reg <= tk_seen_reg | 2'h1;
                end
                CMD_TKEY_HI: begin
                    traffic_key_reg[KEY_W-1:HALF_W] <= aes_dout;
                    tk_seen_reg <= tk_seen_reg | 2'h2;
                end
                default: ;
            endcase
        end else if (init_seen_reg == INIT_ALL) begin
            off_pw_reg    <= stg_off_reg;
            rdr_pw_reg    <= stg_rdr_reg;
            kwk_reg       <= stg_kwk_reg;
            init_reg      <= 1'b1;
            init_seen_reg <= '0;
        end
    end

    // ==========================================================
    // Answers to the reader; status holds no secret fields
    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            rsp_valid <= 1'b0;
            rsp_code  <= RSP_OK;
        end else begin
            rsp_valid <= 1'b0;
            if (take && (!permit || !needs_unwrap)) begin
                rsp_valid <= 1'b1;
                rsp_code  <= permit ? RSP_OK : RSP_DENIED;
            end else if (state_reg == ST_UNWRAP && aes_done) begin
                rsp_valid <= 1'b1;
                rsp_code  <= (pend_cmd_reg <= CMD_AUTH_RDR &&
                              (!pw_legal(aes_dout[PW_W-1:0]) ||
                               aes_dout[PW_W-1:0] != (pend_cmd_reg ==
                               CMD_AUTH_OFF ? off_pw_reg : rdr_pw_reg)))
                             ? RSP_BADPW : RSP_OK;
            end
        end
    end

    // ==========================================================
    // Registered outputs and host gating
    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            cmd_ready     <= 1'b0;
            role_out      <= ROLE_NONE;
            init_out      <= 1'b0;
            ctr_key       <= '0;
            ctr_key_valid <= 1'b0;
            host_out_en   <= 1'b0;
            test_busy     <= 1'b1;
            error_out     <= 1'b0;
        end else begin
            cmd_ready     <= (state_next == ST_IDLE) && !take;
            role_out      <= role_reg;
            init_out      <= init_reg;
            ctr_key_valid <= tk_valid && role_reg == ROLE_READER;
            ctr_key       <= (tk_valid && role_reg == ROLE_READER)
                             ? traffic_key_reg : '0;
            host_out_en   <= (state_next == ST_IDLE ||
                              state_next == ST_UNWRAP) &&
                             role_reg == ROLE_READER && tk_valid;
            test_busy     <= state_next inside {ST_CRC, ST_CRC_CHK,
                                               ST_KAT_ENC, ST_KAT_DEC};
            error_out     <= (state_next == ST_ERROR);
        end
    end

    // ==========================================================
    // Checks
    sequence kat_pass_s;
        state_reg == ST_KAT_DEC && aes_done && aes_dout == KAT_PT;
    endsequence
    sequence zero_take_s;
        take && cmd_code == CMD_ZEROIZE && state_reg == ST_IDLE;
    endsequence

    role_clear_a: assert property (@(posedge clk_sys)
        sys_rst |=> role_reg == ROLE_NONE ##1 role_out == ROLE_NONE)
        else $error("role kept over power cycle");
    tkey_clear_a: assert property (@(posedge clk_sys)
        sys_rst |=> traffic_key_reg == '0 && !tk_valid)
        else $error("traffic key kept over power cycle");
    auto_start_a: assert property (@(posedge clk_sys)
        $fell(sys_rst) |-> state_reg == ST_CRC && test_busy)
        else $error("self test did not start");
    replug_test_a: assert property (@(posedge clk_sys)
        host_replug |=> state_reg == ST_CRC && fw_cnt_reg == '0)
        else $error("replug did not rerun tests");
    kat_pass_a: assert property (@(posedge clk_sys) disable iff (rst_all)
        kat_pass_s |=> state_reg == ST_IDLE ##1 cmd_ready)
        else $error("idle not reached after tests");
    crc_fail_a: assert property (@(posedge clk_sys) disable iff (rst_all)
        state_reg == ST_CRC_CHK && crc_reg != FW_CRC
        |=> state_reg == ST_ERROR ##1 error_out)
        else $error("crc mismatch not trapped");
    out_block_a: assert property (@(posedge clk_sys)
        (test_busy || error_out || state_reg == ST_ZERO) |-> !host_out_en)
        else $error("host output during test or error");
    deny_noauth_a: assert property (@(posedge clk_sys)
        disable iff (rst_all)
        take && role_reg == ROLE_NONE && cmd_code == CMD_DATA
        |=> rsp_valid && rsp_code == RSP_DENIED)
        else $error("service without role");
    reader_gate_a: assert property (@(posedge clk_sys)
        disable iff (rst_all)
        take && !init_reg && cmd_code == CMD_AUTH_RDR
        |=> rsp_valid && rsp_code == RSP_DENIED ##1 role_reg != ROLE_READER)
        else $error("reader before initialization");
    zero_all_a: assert property (@(posedge clk_sys)
        disable iff (rst_all)
        zero_take_s |=> traffic_key_reg == '0 && kwk_reg == DEF_KWK &&
        off_pw_reg == DEF_OFF_PW && rdr_pw_reg == DEF_RDR_PW && !init_reg)
        else $error("zeroize incomplete");
    error_hold_a: assert property (@(posedge clk_sys)
        disable iff (rst_all)
        state_reg == ST_ERROR |=> state_reg == ST_ERROR && !cmd_ready)
        else $error("error state left");

endmodule : rka_access_ctrl

// *** rka_pkg.sv ***
// Constants and types for the role and key custody controller.
// Assumes a single 200 MHz system clock; AES core lives outside.
package rka_pkg;
    // ==========================================================
    // Widths
    localparam int unsigned KEY_W   = 256;
    localparam int unsigned BLK_W   = 128;
    localparam int unsigned PW_W    = 64;
    localparam int unsigned CHAR_W  = 8;
    localparam int unsigned PW_CHARS = 8;
    localparam int unsigned HALF_W  = 128;
    // ==========================================================
    // Commands from the wireless link
    localparam logic [3:0] CMD_AUTH_OFF = 4'h0;
    localparam logic [3:0] CMD_AUTH_RDR = 4'h1;
    localparam logic [3:0] CMD_INIT_PW  = 4'h2;
    localparam logic [3:0] CMD_INIT_KLO = 4'h3;
    localparam logic [3:0] CMD_INIT_KHI = 4'h4;
    localparam logic [3:0] CMD_TKEY_LO  = 4'h5;
    localparam logic [3:0] CMD_TKEY_HI  = 4'h6;
    localparam logic [3:0] CMD_DATA     = 4'h7;
    localparam logic [3:0] CMD_ZEROIZE  = 4'h8;
    localparam logic [3:0] CMD_SELFTEST = 4'h9;
    localparam logic [3:0] CMD_STATUS   = 4'ha;
    // ==========================================================
    // Answers
    localparam logic [1:0] RSP_OK     = 2'h0;
    localparam logic [1:0] RSP_DENIED = 2'h1;
    localparam logic [1:0] RSP_BADPW  = 2'h2;
    typedef enum logic [1:0] {ROLE_NONE, ROLE_OFFICER, ROLE_READER}
        rka_role_t;
    // ==========================================================
    // Defaults and known answers (values arbitrary)
    localparam logic [PW_W-1:0]   DEF_OFF_PW = 64'h4f66_6669_6365_7231;
    localparam logic [PW_W-1:0]   DEF_RDR_PW = 64'h5265_6164_6572_3031;
    localparam logic [KEY_W-1:0]  DEF_KWK    = {8{32'h5a3c_96e1}};
    localparam logic [KEY_W-1:0]  KAT_KEY    = {8{32'h0f1e_2d3c}};
    localparam logic [BLK_W-1:0]  KAT_PT     = {4{32'h0011_2233}};
    localparam logic [BLK_W-1:0]  KAT_CT     = {4{32'h8ea2_b7ca}};
    localparam logic [CHAR_W-1:0] PW_MIN_CHAR = 8'h20;
    localparam logic [15:0]       CRC_INIT   = 16'hffff;
    localparam logic [15:0]       CRC_POLY   = 16'h1021;
    localparam logic [2:0]        INIT_ALL   = 3'h7;
    localparam logic [1:0]        TK_ALL     = 2'h3;
endpackage : rka_pkg

// *** rka_partner.sv ***
// Behavioural far side: AES core stand-in and firmware image ROM.
// Assumes the controller holds AES inputs from start until done.
`timescale 1ns/1ps
module rka_partner
    import rka_pkg::*;
(
    // Clock and test controls
    input  wire logic                      clk_sys,
    input  wire logic                      slow,
    input  wire logic                      corrupt,
    // AES core side
    input  wire logic                      aes_start,
    input  wire logic                      aes_decrypt,
    input  wire logic [rka_pkg::KEY_W-1:0] aes_key,
    input  wire logic [rka_pkg::BLK_W-1:0] aes_din,
    output logic                           aes_done,
    output logic [rka_pkg::BLK_W-1:0]      aes_dout,
    // Firmware ROM side
    input  wire logic [15:0]               fw_rd_addr,
    output logic [7:0]                     fw_rd_data
);
    // ==========================================================
    // AES stand-in: keyed XOR, mapped so the known answer holds
    logic [7:0] wait_cnt;

    function automatic logic [BLK_W-1:0] pad(input logic [KEY_W-1:0] k);
        return (k == KAT_KEY) ? (KAT_PT ^ KAT_CT) : (k[255:128] ^ k[127:0]);
    endfunction : pad

    initial begin
        wait_cnt = 8'h00;
        aes_done = 1'b0;
        aes_dout = '0;
    end

    always @(posedge clk_sys) begin
        aes_done <= 1'b0;
        // Result lines do not hold a stale value between answers
        aes_dout <= ~aes_dout;
        if (aes_start) begin
            wait_cnt <= slow ? 8'h08 : 8'h01;
        end else if (wait_cnt != 8'h00) begin
            wait_cnt <= wait_cnt - 8'h01;
            if (wait_cnt == 8'h01) begin
                aes_done <= 1'b1;
                aes_dout <= aes_din ^ pad(aes_key);
            end
        end
    end
    // ==========================================================
    // Firmware ROM, one cycle read latency
    always @(posedge clk_sys) begin
        fw_rd_data <= (fw_rd_addr[7:0] * 8'h1d + 8'h4b) ^ {7'h0, corrupt};
    end
endmodule : rka_partner

// *** test_role_key_access_control.sv ***
// Self-checking bench for the role and key custody controller.
// Assumes rka_partner stands in for the AES core and firmware ROM.
`timescale 1ns/1ps
module test_role_key_access_control;
    import rka_pkg::*;
    // ==========================================================
    // Values and table
    localparam logic [63:0]  NEW_OFF = 64'h2a4f_6666_2d4e_6577;
    localparam logic [63:0]  NEW_RDR = 64'h7e52_6464_2d4e_6577;
    localparam logic [63:0]  BAD_OFF = {DEF_OFF_PW[63:8], 8'h20};
    localparam logic [255:0] NEW_KEY = {4{64'hc3a5_1e7d_6b29_f084}};
    localparam logic [255:0] TK      = {4{64'h9d13_57ac_e024_68bf}};
    typedef struct packed {
        logic [3:0] code; logic use_new; logic [127:0] data;
        logic [1:0] rsp; rka_role_t role; logic init; logic tkv;
    } rka_row_t;
    localparam rka_row_t ROWS [18] = '{
        '{CMD_STATUS, 1'b0, '0, RSP_DENIED, ROLE_NONE, 1'b0, 1'b0},
        '{CMD_AUTH_RDR, 1'b0, {64'h0, DEF_RDR_PW}, RSP_DENIED, ROLE_NONE,
          1'b0, 1'b0},
        '{CMD_DATA, 1'b0, '0, RSP_DENIED, ROLE_NONE, 1'b0, 1'b0},
        '{CMD_AUTH_OFF, 1'b0, {64'h0, BAD_OFF}, RSP_BADPW, ROLE_NONE,
          1'b0, 1'b0},
        '{CMD_AUTH_OFF, 1'b0, {64'h0, DEF_OFF_PW}, RSP_OK, ROLE_OFFICER,
          1'b0, 1'b0},
        '{CMD_AUTH_RDR, 1'b0, {64'h0, DEF_RDR_PW}, RSP_DENIED, ROLE_OFFICER,
          1'b0, 1'b0},
        '{CMD_INIT_PW, 1'b0, {NEW_OFF, NEW_RDR}, RSP_OK, ROLE_OFFICER,
          1'b0, 1'b0},
        '{CMD_INIT_KLO, 1'b0, NEW_KEY[127:0], RSP_OK, ROLE_OFFICER,
          1'b0, 1'b0},
        '{CMD_INIT_KHI, 1'b0, NEW_KEY[255:128], RSP_OK, ROLE_OFFICER,
          1'b1, 1'b0},
        '{CMD_AUTH_RDR, 1'b1, {64'h0, NEW_RDR}, RSP_OK, ROLE_READER,
          1'b1, 1'b0},
        '{CMD_TKEY_LO, 1'b1, TK[127:0], RSP_OK, ROLE_READER, 1'b1, 1'b0},
        '{CMD_TKEY_HI, 1'b1, TK[255:128], RSP_OK, ROLE_READER, 1'b1, 1'b1},
        '{CMD_DATA, 1'b1, '0, RSP_OK, ROLE_READER, 1'b1, 1'b1},
        '{CMD_STATUS, 1'b1, '0, RSP_OK, ROLE_READER, 1'b1, 1'b1},
        '{4'hf, 1'b1, '0, RSP_DENIED, ROLE_READER, 1'b1, 1'b1},
        '{CMD_ZEROIZE, 1'b1, '0, RSP_OK, ROLE_NONE, 1'b0, 1'b0},
        '{CMD_AUTH_OFF, 1'b1, {64'h0, NEW_OFF}, RSP_BADPW, ROLE_NONE,
          1'b0, 1'b0},
        '{CMD_AUTH_OFF, 1'b0, {64'h0, DEF_OFF_PW}, RSP_OK, ROLE_OFFICER,
          1'b0, 1'b0}};

    function automatic logic [15:0] fw_crc();
        logic [15:0] c;
        logic [7:0]  b;
        c = CRC_INIT;
        for (int i = 0; i < 16; i++) begin
            b = 8'(i) * 8'h1d + 8'h4b;
            for (int j = 7; j >= 0; j--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ b[j]) ? CRC_POLY : 16'h0);
            end
        end
        return c;
    endfunction : fw_crc

    function automatic logic [BLK_W-1:0] pad(input logic [KEY_W-1:0] k);
        return (k == KAT_KEY) ? (KAT_PT ^ KAT_CT) : (k[255:128] ^ k[127:0]);
    endfunction : pad
    // ==========================================================
    // Signals
    logic             clk_sys = 1'b0;
    logic             sys_rst = 1'b1;
    logic             host_replug = 1'b0;
    logic             cmd_valid = 1'b0;
    logic             cmd_paired = 1'b0;
    logic [3:0]       cmd_code = 4'h0;
    logic [BLK_W-1:0] cmd_data = '0;
    logic             slow = 1'b0;
    logic             corrupt = 1'b0;
    logic             cmd_ready, rsp_valid, init_out, aes_start, aes_decrypt;
    logic             aes_done, ctr_key_valid, host_out_en, test_busy;
    logic             error_out;
    logic [1:0]       rsp_code;
    rka_role_t        role_out;
    logic [KEY_W-1:0] aes_key, ctr_key;
    logic [BLK_W-1:0] aes_din, aes_dout;
    logic [15:0]      fw_rd_addr;
    logic [7:0]       fw_rd_data;
    logic [1:0]       kat_seen = 2'h0;
    int               error_cnt = 0;
    int               comparisons = 0;
    int               cycles = 0;

    always #2.5 clk_sys = ~clk_sys;

    rka_access_ctrl #(.FW_BYTES(16), .FW_CRC(fw_crc())) rka_access_ctrl_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .host_replug(host_replug),
        .cmd_valid(cmd_valid), .cmd_paired(cmd_paired), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_code(rsp_code), .role_out(role_out), .init_out(init_out),
        .aes_start(aes_start), .aes_decrypt(aes_decrypt), .aes_key(aes_key),
        .aes_din(aes_din), .aes_done(aes_done), .aes_dout(aes_dout),
        .fw_rd_addr(fw_rd_addr), .fw_rd_data(fw_rd_data), .ctr_key(ctr_key),
        .ctr_key_valid(ctr_key_valid), .host_out_en(host_out_en),
        .test_busy(test_busy), .error_out(error_out));

    rka_partner rka_partner_inst (
        .clk_sys(clk_sys), .slow(slow), .corrupt(corrupt),
        .aes_start(aes_start), .aes_decrypt(aes_decrypt), .aes_key(aes_key),
        .aes_din(aes_din), .aes_done(aes_done), .aes_dout(aes_dout),
        .fw_rd_addr(fw_rd_addr), .fw_rd_data(fw_rd_data));
    // ==========================================================
    // Tasks
    task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_ready();
        int n = 0;
        while (cmd_ready !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        chk(cmd_ready, 1'b1);
    endtask : wait_ready

    task automatic send(input logic [3:0] c, input logic [127:0] d,
                        output logic [1:0] rc);
        int n = 0;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_paired = 1'b1;
        cmd_code = c;
        cmd_data = d;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        rc = rsp_code;
        wait_ready();
        // Role, init commit and key outputs settle two cycles later
        repeat (2) @(negedge clk_sys);
    endtask : send

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    // ==========================================================
    // Monitors and timeout
    always @(negedge clk_sys) begin
        if (test_busy === 1'b1 || error_out === 1'b1) begin
            chk(host_out_en, 1'b0);
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (sys_rst === 1'b1 || host_replug === 1'b1) begin
            kat_seen <= 2'h0;
        end else if (aes_start === 1'b1 && aes_key === KAT_KEY) begin
            kat_seen <= kat_seen | (aes_decrypt ? 2'h2 : 2'h1);
        end
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [1:0] rc;
        int         n;
        repeat (6) @(negedge clk_sys);
        chk(role_out, ROLE_NONE);
        chk(ctr_key_valid, 1'b0);
        chk(test_busy, 1'b1);
        chk(init_out, 1'b0);
        sys_rst = 1'b0;
        wait_ready();
        chk(kat_seen, 2'h3);
        foreach (ROWS[i]) begin
            slow = i[0];
            send(ROWS[i].code, ROWS[i].data ^
                 pad(ROWS[i].use_new ? NEW_KEY : DEF_KWK), rc);
            chk(rc, ROWS[i].rsp);
            chk(role_out, ROWS[i].role);
            chk(init_out, ROWS[i].init);
            chk(ctr_key, ROWS[i].tkv ? TK : '0);
            chk(ctr_key_valid, ROWS[i].tkv);
            chk(host_out_en, ROWS[i].tkv);
        end
        // Unpaired sender is ignored
        cmd_valid = 1'b1;
        cmd_paired = 1'b0;
        cmd_code = CMD_ZEROIZE;
        repeat (6) begin
            @(negedge clk_sys);
            chk(rsp_valid, 1'b0);
        end
        cmd_valid = 1'b0;
        chk(role_out, ROLE_OFFICER);
        send(CMD_SELFTEST, '0, rc);
        chk(rc, RSP_OK);
        chk(role_out, ROLE_OFFICER);
        // Cable replug reruns the power-up tests
        host_replug = 1'b1;
        @(negedge clk_sys);
        host_replug = 1'b0;
        chk(role_out, ROLE_NONE);
        chk(test_busy, 1'b1);
        chk(cmd_ready, 1'b0);
        wait_ready();
        chk(kat_seen, 2'h3);
        // Bad firmware image latches the error
        corrupt = 1'b1;
        sys_rst = 1'b1;
        @(negedge clk_sys);
        sys_rst = 1'b0;
        n = 0;
        while (test_busy === 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        repeat (20) @(negedge clk_sys);
        chk(error_out, 1'b1);
        chk(cmd_ready, 1'b0);
        chk(host_out_en, 1'b0);
        corrupt = 1'b0;
        sys_rst = 1'b1;
        @(negedge clk_sys);
        sys_rst = 1'b0;
        wait_ready();
        chk(error_out, 1'b0);
        complete_run();
    end
endmodule : test_role_key_access_control
